// ---- pidc_pkg.sv ----
// Function
// - profile code selects response behaviour, values 0..4
// - one evaluation per loop period, output held
// - normalise target and feedback to percent
// - single output spans minus to plus full
// - setpoint profile forces constant target source
// - constant bounded by feedback range, unipolar output
// - over and under target give unipolar output
// - off-tolerance profile drives off inside tolerance
// - error below deadband treated as zero
// - output is P plus I plus D
// - error sum accumulates each evaluation
// - integral gain zero when integral time zero
// - derivative term uses error difference and gain
// - period is loop milliseconds times thousandth
package pidc_pkg;

  ////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_PERIOD  = 8'h04;
  localparam logic [7:0] REG_TGT_MIN = 8'h08;
  localparam logic [7:0] REG_TGT_MAX = 8'h0c;
  localparam logic [7:0] REG_FB_MIN  = 8'h10;
  localparam logic [7:0] REG_FB_MAX  = 8'h14;
  localparam logic [7:0] REG_GAIN    = 8'h18;
  localparam logic [7:0] REG_KI      = 8'h1c;
  localparam logic [7:0] REG_TI      = 8'h20;
  localparam logic [7:0] REG_KD      = 8'h24;
  localparam logic [7:0] REG_TD      = 8'h28;
  localparam logic [7:0] REG_DBAND   = 8'h2c;
  localparam logic [7:0] REG_CONST   = 8'h30;
  localparam logic [7:0] REG_STATUS  = 8'h34;
  localparam logic [7:0] REG_OUTPUT  = 8'h38;
  localparam logic [7:0] REG_ESUM    = 8'h3c;

  // control word fields
  localparam int CTRL_EN_BIT   = 0;
  localparam int CTRL_SRC_BIT  = 1;
  localparam int CTRL_PROF_LSB = 4;

  // reset values
  localparam logic [15:0] PERIOD_RST = 16'h000a;
  localparam logic [15:0] GAIN_RST   = 16'h0100;
  localparam logic [15:0] RANGE_MAX  = 16'h03e8;

  // fixed point: percent with 8 fraction bits
  localparam int          FRAC     = 8;
  localparam logic [31:0] PCT_FULL = 32'h00006400;
  localparam logic [63:0] ESUM_LIM = 64'h0000003fffffffff;

  // timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int MS_NS         = 1000000;
  localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    PROF_SINGLE  = 3'h0,
    PROF_SETPT   = 3'h1,
    PROF_OVER    = 3'h2,
    PROF_UNDER   = 3'h3,
    PROF_OFF_TOL = 3'h4
  } pidc_prof_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_NORM  = 3'b001,
    ST_ERR   = 3'b011,
    ST_TERMS = 3'b010,
    ST_OUT   = 3'b110
  } pidc_state_t;

  typedef struct packed {
    logic               en;
    logic               src_const;
    pidc_prof_t         prof;
    logic        [15:0] period_ms;
    logic signed [15:0] tgt_min;
    logic signed [15:0] tgt_max;
    logic signed [15:0] fb_min;
    logic signed [15:0] fb_max;
    logic        [15:0] gain;
    logic        [15:0] ki;
    logic        [15:0] ti_ms;
    logic        [15:0] kd;
    logic        [15:0] td_ms;
    logic        [15:0] dband;
    logic signed [15:0] const_tgt;
  } pidc_cfg_t;

  typedef struct packed {
    logic signed [15:0] cmd;
    logic               drive_on;
  } pidc_res_t;

endpackage

// ---- pidc_block.sv ----
// Added by the designer: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
module pidc_block
  import pidc_pkg::*;
#(
  parameter int MS_CYC = MS_CYCLES
) (
  input  wire  logic               sys_clk,
  input  wire  logic               nrst,
  input  wire  logic               ce,
  input  wire  logic        [7:0]  avs_address,
  input  wire  logic               avs_read,
  input  wire  logic               avs_write,
  input  wire  logic        [31:0] avs_writedata,
  input  wire  logic        [3:0]  avs_byteenable,
  output logic              [31:0] avs_readdata,
  output logic                     avs_waitrequest,
  input  wire  logic signed [15:0] target_in,
  input  wire  logic signed [15:0] feedback_in,
  output pidc_res_t                pid_res,
  output logic                     pid_valid
);

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // byte-lane merge of a write into the current word
  function automatic logic [31:0] merge(input logic [31:0] o,
                                        input logic [31:0] d,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // source value to percent of its range, clipped to 0..100
  function automatic logic signed [31:0] pct(
      input logic signed [15:0] x,
      input logic signed [15:0] lo,
      input logic signed [15:0] hi);
    logic signed [47:0] span;
    logic signed [47:0] num;
    logic signed [47:0] q;
    span = 48'(hi) - 48'(lo);
    num  = (48'(x) - 48'(lo)) * 48'(signed'(PCT_FULL));
    q    = (span > 0) ? num / span : 48'sd0;
    if (q < 0) begin
      q = 48'sd0;
    end else if (q > 48'(signed'(PCT_FULL))) begin
      q = 48'(signed'(PCT_FULL));
    end
    return q[31:0];
  endfunction

  // clamp wide value into [lo, hi]
  function automatic logic signed [31:0] clamp(
      input logic signed [79:0] v,
      input logic signed [31:0] lo,
      input logic signed [31:0] hi);
    if (v < 80'(lo)) begin
      return lo;
    end else if (v > 80'(hi)) begin
      return hi;
    end
    return v[31:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // state

  pidc_cfg_t          cfg;
  pidc_cfg_t          next_cfg;
  pidc_state_t        state;
  pidc_state_t        next_state;
  logic               ack_q;
  logic        [31:0] rd_word;
  logic        [31:0] wr_word;
  logic        [31:0] ms_cnt;
  logic        [15:0] per_cnt;
  logic signed [31:0] t_pct;
  logic signed [31:0] f_pct;
  logic signed [31:0] err_raw;
  logic signed [31:0] err;
  logic signed [31:0] err_prev;
  logic signed [39:0] esum;
  logic        [31:0] igain;
  logic        [31:0] dgain;
  logic signed [79:0] acc;

  ////////////////////////////////////////////////////////////////////////
  // avalon slave: one wait cycle, then answer

  wire req      = avs_read | avs_write;
  wire wr_en    = avs_write & ack_q;

  assign avs_waitrequest = req & ~ack_q;
  assign wr_word = merge(rd_word, avs_writedata, avs_byteenable);

  // readback; unmapped offsets read zero
  always_comb begin
    rd_word = 32'h00000000;
    case (avs_address)
      REG_CTRL: begin
        rd_word[CTRL_EN_BIT]  = cfg.en;
        rd_word[CTRL_SRC_BIT] = cfg.src_const;
        rd_word[CTRL_PROF_LSB +: 3] = cfg.prof;
      end
      REG_PERIOD:  rd_word[15:0] = cfg.period_ms;
      REG_TGT_MIN: rd_word = 32'(cfg.tgt_min);
      REG_TGT_MAX: rd_word = 32'(cfg.tgt_max);
      REG_FB_MIN:  rd_word = 32'(cfg.fb_min);
      REG_FB_MAX:  rd_word = 32'(cfg.fb_max);
      REG_GAIN:    rd_word[15:0] = cfg.gain;
      REG_KI:      rd_word[15:0] = cfg.ki;
      REG_TI:      rd_word[15:0] = cfg.ti_ms;
      REG_KD:      rd_word[15:0] = cfg.kd;
      REG_TD:      rd_word[15:0] = cfg.td_ms;
      REG_DBAND:   rd_word[15:0] = cfg.dband;
      REG_CONST:   rd_word = 32'(cfg.const_tgt);
      REG_STATUS:  rd_word[3:0] = {state, cfg.en};
      REG_OUTPUT:  rd_word = {15'h0000, pid_res.drive_on, pid_res.cmd};
      REG_ESUM:    rd_word = esum[31:0];
      default:     rd_word = 32'h00000000;
    endcase
  end

  // register writes; status words are read only
  always_comb begin
    next_cfg = cfg;
    if (wr_en) begin
      case (avs_address)
        REG_CTRL: begin
          next_cfg.en   = wr_word[CTRL_EN_BIT];
          next_cfg.prof = pidc_prof_t'(wr_word[CTRL_PROF_LSB +: 3]);
          next_cfg.src_const = wr_word[CTRL_SRC_BIT];
        end
        REG_PERIOD:  next_cfg.period_ms = wr_word[15:0];
        REG_TGT_MIN: next_cfg.tgt_min   = wr_word[15:0];
        REG_TGT_MAX: next_cfg.tgt_max   = wr_word[15:0];
        REG_FB_MIN:  next_cfg.fb_min    = wr_word[15:0];
        REG_FB_MAX:  next_cfg.fb_max    = wr_word[15:0];
        REG_GAIN:    next_cfg.gain      = wr_word[15:0];
        REG_KI:      next_cfg.ki        = wr_word[15:0];
        REG_TI:      next_cfg.ti_ms     = wr_word[15:0];
        REG_KD:      next_cfg.kd        = wr_word[15:0];
        REG_TD:      next_cfg.td_ms     = wr_word[15:0];
        REG_DBAND:   next_cfg.dband     = wr_word[15:0];
        REG_CONST:   next_cfg.const_tgt = wr_word[15:0];
        default:     next_cfg = cfg;
      endcase
    end
    // setpoint profile pins the target to the constant
    if (next_cfg.prof == PROF_SETPT) begin
      next_cfg.src_const = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      ack_q <= 1'b0;
      avs_readdata <= 32'h00000000;
      cfg <= '{en: 1'b0, src_const: 1'b0, prof: PROF_SINGLE,
               period_ms: PERIOD_RST, tgt_min: 16'h0000,
               tgt_max: RANGE_MAX, fb_min: 16'h0000,
               fb_max: RANGE_MAX, gain: GAIN_RST, ki: 16'h0000,
               ti_ms: 16'h0000, kd: 16'h0000, td_ms: 16'h0000,
               dband: 16'h0000, const_tgt: 16'h0000};
    end else if (ce) begin
      ack_q <= req & ~ack_q;
      avs_readdata <= rd_word;
      cfg <= next_cfg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // loop timebase: millisecond tick, then period count

  wire ms_tick   = ms_cnt == 32'(MS_CYC - 1);
  wire [15:0] per_last = (cfg.period_ms == 16'h0000) ? 16'h0000
                       : cfg.period_ms - 16'h0001;
  wire loop_tick = cfg.en & ms_tick & (per_cnt >= per_last);

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      ms_cnt  <= 32'h00000000;
      per_cnt <= 16'h0000;
    end else if (ce) begin
      ms_cnt  <= (ms_tick | ~cfg.en) ? 32'h00000000 : ms_cnt + 32'h1;
      if (loop_tick | ~cfg.en) begin
        per_cnt <= 16'h0000;
      end else if (ms_tick) begin
        per_cnt <= per_cnt + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // evaluation datapath

  // constant target is scaled by the feedback range
  wire signed [31:0] tgt_now = cfg.src_const
      ? pct(cfg.const_tgt, cfg.fb_min, cfg.fb_max)
      : pct(target_in, cfg.tgt_min, cfg.tgt_max);
  wire signed [31:0] fb_now = pct(feedback_in, cfg.fb_min, cfg.fb_max);

  // error and deadband
  assign err_raw = t_pct - f_pct;
  wire [31:0] err_abs = err_raw[31] ? 32'(-err_raw) : 32'(err_raw);
  wire in_band = err_abs < 32'(cfg.dband);
  wire signed [31:0] err_use = in_band ? 32'sd0 : err_raw;

  // gains; milliseconds cancel, giving T in seconds implicitly
  wire [31:0] ki_t = 32'(cfg.ki) * 32'(cfg.period_ms);
  wire [31:0] kd_t = 32'(cfg.kd) * 32'(cfg.td_ms);
  wire [31:0] igain_now = (cfg.ti_ms == 16'h0000) ? 32'h0
                        : ki_t / 32'(cfg.ti_ms);
  wire [31:0] dgain_now = (cfg.period_ms == 16'h0000) ? 32'h0
                        : kd_t / 32'(cfg.period_ms);

  // error sum saturated far above any useful value
  wire signed [63:0] sum_wide = 64'(esum) + 64'(err);
  wire signed [39:0] next_esum =
      (sum_wide >  signed'(ESUM_LIM)) ? 40'(ESUM_LIM) :
      (sum_wide < -signed'(ESUM_LIM)) ? 40'(-signed'(ESUM_LIM)) :
      sum_wide[39:0];

  // 80-bit sum keeps every product exact before the clamp
  wire signed [79:0] p_term = 80'(signed'(cfg.gain)) * 80'(err)
                            ;
  wire signed [79:0] i_term = 80'(signed'({1'b0, igain}))
                            * 80'(next_esum);
  wire signed [79:0] d_term = 80'(signed'({1'b0, dgain}))
                            * 80'(err - err_prev);
  wire signed [79:0] acc_now = (p_term + i_term + d_term) >>> FRAC;

  // profile shaping of the accumulated result
  wire signed [31:0] pos_lim = signed'(PCT_FULL);
  wire signed [31:0] neg_lim = -signed'(PCT_FULL);
  wire signed [31:0] out_bip = clamp(acc, neg_lim, pos_lim);
  wire signed [31:0] out_pos = clamp(acc, 32'sd0, pos_lim);
  wire signed [31:0] out_neg = clamp(-acc, 32'sd0, pos_lim);
  wire tol_off = (cfg.prof == PROF_OFF_TOL) & in_band;

  logic signed [31:0] shaped;
  always_comb begin
    case (cfg.prof)
      PROF_SINGLE:  shaped = out_bip;
      PROF_SETPT:   shaped = out_pos;
      PROF_OVER:    shaped = out_neg;
      PROF_UNDER:   shaped = out_pos;
      PROF_OFF_TOL: shaped = tol_off ? 32'sd0 : out_pos;
      default:      shaped = 32'sd0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // evaluation sequencer

  always_comb begin
    case (state)
      ST_IDLE:  next_state = loop_tick ? ST_NORM : ST_IDLE;
      ST_NORM:  next_state = ST_ERR;
      ST_ERR:   next_state = ST_TERMS;
      ST_TERMS: next_state = ST_OUT;
      ST_OUT:   next_state = ST_IDLE;
      default:  next_state = ST_IDLE;
    endcase
  end

  // a tick that lands mid-evaluation is skipped, the
  // sequence is far shorter than one millisecond
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      state <= ST_IDLE;
    end else if (ce) begin
      state <= next_state;
    end
  end

  // datapath registers; history cleared only by reset
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      t_pct    <= 32'sd0;
      f_pct    <= 32'sd0;
      err      <= 32'sd0;
      err_prev <= 32'sd0;
      esum     <= 40'sd0;
      igain    <= 32'h0;
      dgain    <= 32'h0;
      acc      <= 80'sd0;
    end else if (ce) begin
      case (state)
        ST_NORM: begin
          t_pct <= tgt_now;
          f_pct <= fb_now;
        end
        ST_ERR: begin
          err   <= err_use;
          igain <= igain_now;
          dgain <= dgain_now;
        end
        ST_TERMS: begin
          acc      <= acc_now;
          esum     <= next_esum;
          err_prev <= err;
        end
        default: begin
          acc <= acc;
        end
      endcase
    end
  end

  // output stands between evaluations
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      pid_res   <= '{cmd: 16'sd0, drive_on: 1'b0};
      pid_valid <= 1'b0;
    end else if (ce) begin
      pid_valid <= state == ST_OUT;
      if (state == ST_OUT) begin
        pid_res.cmd      <= shaped[15:0];
        pid_res.drive_on <= (shaped != 32'sd0) & ~tol_off;
      end
    end
  end

endmodule

// ---- pidc_block_monitor.sv ----
`timescale 1ns/10ps
module pidc_checker
  import pidc_pkg::*;
#(
  parameter int MS_CYC = MS_CYCLES
) (
  input wire logic               sys_clk,
  input wire logic               nrst,
  input wire logic               ce,
  input wire logic        [7:0]  avs_address,
  input wire logic               avs_read,
  input wire logic               avs_write,
  input wire logic        [31:0] avs_writedata,
  input wire logic        [3:0]  avs_byteenable,
  input wire logic        [31:0] avs_readdata,
  input wire logic               avs_waitrequest,
  input wire logic signed [15:0] target_in,
  input wire logic signed [15:0] feedback_in,
  input pidc_res_t               pid_res,
  input wire logic               pid_valid
);
  wire req = avs_read | avs_write;

  //////////////////////////////////////////////////////////////////////
  // one clock domain, reset masks every property
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  // bus answers after exactly one wait cycle, then drops ack
  wait_once_a: assert property (avs_waitrequest && ce |=> !avs_waitrequest)
    else $error("waitrequest held longer than one cycle");
  idle_ready_a: assert property (!req |-> !avs_waitrequest)
    else $error("waitrequest raised with no request");
  ack_once_a: assert property (req && !avs_waitrequest && ce
    |=> !req || avs_waitrequest)
    else $error("second acknowledge without new wait cycle");
  unmapped_zero_a: assert property (avs_read && !avs_waitrequest
    && avs_address >= 8'h40 |-> avs_readdata == 32'h0)
    else $error("unmapped read returned nonzero data");

  // loop ticks are at least a millisecond apart, so eight idle cycles is safe
  tick_gap_a: assert property (pid_valid |=> !pid_valid [*8])
    else $error("evaluations closer than a loop period");
  res_hold_a: assert property (!pid_valid && $past(nrst)
    |-> pid_res == $past(pid_res))
    else $error("result changed between evaluations");
  cmd_range_a: assert property (pid_res.cmd >= -16'sh6400
    && pid_res.cmd <= 16'sh6400)
    else $error("command outside full scale");
  drive_zero_a: assert property (pid_res.cmd == 16'h0
    |-> !pid_res.drive_on)
    else $error("drive on with zero command");
  reset_clear_a: assert property (!$past(nrst)
    |-> !pid_valid && pid_res == '0)
    else $error("result not cleared by reset");
endmodule

bind pidc_block pidc_checker #(.MS_CYC(MS_CYC)) i_pidc_checker (
  .sys_clk, .nrst, .ce, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
  .target_in, .feedback_in, .pid_res, .pid_valid);

// ---- pidc_io_model.sv ----
`timescale 1ns/10ps
module pidc_io_model
  import pidc_pkg::*;
(
  input wire logic signed [15:0] tgt_raw,
  input wire logic signed [15:0] fb_raw,
  input wire logic               sys_clk,
  input wire logic               nrst,
  input pidc_res_t               pid_res,
  input wire logic               pid_valid,
  output logic signed     [15:0] target_in,
  output logic signed     [15:0] feedback_in,
  output logic signed     [15:0] drive_cmd
);
  //////////////////////////////////////////////////////////////////////
  // source blocks present raw values a cycle late, as a real input would;
  // the output block only moves when a new command is announced
  always_ff @(posedge sys_clk) begin
    target_in   <= tgt_raw;
    feedback_in <= fb_raw;
    if (!nrst) begin
      drive_cmd <= 16'h0;
    end else if (pid_valid) begin
      drive_cmd <= pid_res.drive_on ? pid_res.cmd : 16'h0;
    end
  end
endmodule

// ---- test_pidc_block.sv ----
`timescale 1ns/10ps
module test_pidc_block;
  import pidc_pkg::*;
  logic               sys_clk = 1'b0;
  logic               nrst = 1'b0;
  logic               ce = 1'b1;
  logic        [7:0]  avs_address = 8'h0;
  logic               avs_read = 1'b0;
  logic               avs_write = 1'b0;
  logic        [31:0] avs_writedata = 32'h0;
  logic        [3:0]  avs_byteenable = 4'hf;
  logic        [31:0] avs_readdata;
  logic               avs_waitrequest;
  logic signed [15:0] tgt_raw = 16'h0;
  logic signed [15:0] fb_raw = 16'h0;
  logic signed [15:0] target_in;
  logic signed [15:0] feedback_in;
  logic signed [15:0] drive_cmd;
  pidc_res_t          pid_res;
  logic               pid_valid;
  logic        [31:0] rd;
  int                 n_mismatch = 0;
  int                 total_checks = 0;
  int                 cyc = 0;

  always #20 sys_clk = ~sys_clk;

  // ten cycles per millisecond keeps loop periods short
  pidc_block #(.MS_CYC(10)) i_pidc_block (.sys_clk, .nrst, .ce,
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .target_in, .feedback_in, .pid_res,
    .pid_valid);
  pidc_io_model i_pidc_io_model (.tgt_raw, .fb_raw, .sys_clk, .nrst,
    .pid_res, .pid_valid, .target_in, .feedback_in, .drive_cmd);

  //////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // hang guard: whole run needs under a thousand cycles
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_mismatch++;
      wrap_up;
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // request held until waitrequest is sampled low; no latency assumed
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge sys_clk); while (avs_waitrequest);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask

  // waits for k result pulses
  task automatic ev(input int k);
    repeat (k) do @(posedge sys_clk); while (pid_valid !== 1'b1);
  endtask

  // e holds {drive_on, cmd}; the output block follows a cycle later
  task automatic ev_is(input logic [31:0] e);
    chk({15'h0, pid_res.drive_on, pid_res.cmd}, e);
    @(posedge sys_clk);
    chk({16'h0, drive_cmd}, e[16] ? {16'h0, e[15:0]} : 32'h0);
  endtask

  task automatic inp(input logic [15:0] t, input logic [15:0] f);
    tgt_raw <= t;
    fb_raw <= f;
  endtask

  // two evaluations so the new inputs surely reach a full pass
  task automatic settle(input logic [15:0] t, input logic [15:0] f,
                        input logic [31:0] e);
    inp(t, f);
    ev(2);
    ev_is(e);
  endtask

  //////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rdc(REG_CTRL, 32'h0);
    rdc(REG_PERIOD, 32'ha);
    rdc(REG_GAIN, 32'h100);
    rdc(REG_FB_MAX, 32'h3e8);
    rdc(8'h40, 32'h0);
    rdc(REG_STATUS, 32'h0);
    wr(REG_OUTPUT, 32'h12345);
    rdc(REG_OUTPUT, 32'h0);
    wr(REG_PERIOD, 32'h1);
    $display("t_regs done");
  endtask

  task automatic t_single;
    wr(REG_CTRL, 32'h1);
    settle(16'h1f4, 16'hfa, 32'h11900);
    settle(16'h0, 16'h3e8, 32'h19c00);
    settle(16'h5dc, 16'hfff6, 32'h16400);
    $display("t_single done");
  endtask

  // odd entries select under target, upper half flips the error sign
  task automatic t_push;
    for (int i = 0; i < 4; i++) begin
      wr(REG_CTRL, i[0] ? 32'h31 : 32'h21);
      settle(i[1] ? 16'h1f4 : 16'hfa, i[1] ? 16'hfa : 16'h1f4,
             (i[0] == i[1]) ? 32'h11900 : 32'h0);
    end
    $display("t_push done");
  endtask

  // error of 0x1900 sits just inside, then exactly on, the band
  task automatic t_band;
    wr(REG_DBAND, 32'h1901);
    wr(REG_CTRL, 32'h1);
    settle(16'h1f4, 16'hfa, 32'h0);
    wr(REG_CTRL, 32'h41);
    settle(16'h1f4, 16'hfa, 32'h0);
    wr(REG_DBAND, 32'h1900);
    settle(16'h1f4, 16'hfa, 32'h11900);
    wr(REG_DBAND, 32'h0);
    $display("t_band done");
  endtask

  task automatic t_setpt;
    wr(REG_CTRL, 32'h11);
    rdc(REG_CTRL, 32'h13);
    wr(REG_CONST, 32'h1f4);
    settle(16'h0, 16'hfa, 32'h11900);
    wr(REG_CONST, 32'h7d0);
    settle(16'h0, 16'hfa, 32'h14b00);
    wr(REG_CONST, 32'h0);
    settle(16'h3e8, 16'hfa, 32'h0);
    $display("t_setpt done");
  endtask

  // history is only cleared by reset, so start from a fresh one
  task automatic t_terms;
    nrst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    chk({15'h0, pid_res}, 32'h0);
    rdc(REG_ESUM, 32'h0);
    inp(16'h1f4, 16'hfa);
    wr(REG_PERIOD, 32'h1);
    wr(REG_GAIN, 32'h0);
    wr(REG_KI, 32'h100);
    wr(REG_TI, 32'h1);
    wr(REG_CTRL, 32'h1);
    ev(1);
    ev_is(32'h11900);
    ev(1);
    ev_is(32'h13200);
    rdc(REG_ESUM, 32'h3200);
    wr(REG_TI, 32'h0);
    ev(2);
    ev_is(32'h0);
    wr(REG_KD, 32'h100);
    wr(REG_TD, 32'h2);
    ev(2);
    ev_is(32'h0);
    inp(16'h2ee, 16'hfa);
    for (int i = 0; i < 3 && pid_res.cmd == 16'h0; i++) ev(1);
    ev_is(32'h13200);
    ev(1);
    ev_is(32'h0);
    $display("t_terms done");
  endtask

  task automatic t_period;
    int n;
    n = 0;
    wr(REG_PERIOD, 32'h3);
    ev(2);
    do begin
      @(posedge sys_clk);
      n++;
    end while (pid_valid !== 1'b1);
    chk(n, 32'h1e);
    // a frozen clock enable stretches the period by the frozen cycles
    ce <= 1'b0;
    repeat (15) @(posedge sys_clk);
    ce <= 1'b1;
    n = 15;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pid_valid !== 1'b1);
    chk(n, 32'h2d);
    $display("t_period done");
  endtask

  initial begin
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    t_regs;
    t_single;
    t_push;
    t_band;
    t_setpt;
    t_terms;
    t_period;
    wrap_up;
  end
endmodule
